// [hdl/adcmx_pkg.sv]
// constants for the converter frame sequencer
package adcmx_pkg;
  // register byte addresses
  localparam logic [15:0] ADDR_SEL10_COUNT = 16'h2100;
  localparam logic [15:0] ADDR_SEL0_SEL1 = 16'h2105;
  localparam logic [15:0] ADDR_CHOP = 16'h2106;
  localparam logic [15:0] ADDR_FILTER_DIFF = 16'h210C;
  localparam logic [15:0] ADDR_STATUS = 16'h2110;
  localparam logic [15:0] ADDR_FRAME_FIR_LO = 16'h2111;
  localparam logic [15:0] ADDR_FRAME_FIR_HI = 16'h2112;
  localparam logic [15:0] ADDR_CLOCK_CFG = 16'h2200;
  localparam logic [15:0] ADDR_PREAMP = 16'h2704;
  localparam logic [15:0] ADDR_REMOTE = 16'h2709;
  // number of slot-select bytes, 0x2100 up to 0x2105
  localparam int SEL_BYTES = 6;
  // field positions
  localparam int SLOT_COUNT_LSB = 4;
  localparam int CHOP_LSB = 2;
  localparam int FILTER_LEN_LSB = 1;
  localparam int DIFF_LSB = 4;
  localparam int PLL_FAST_BIT = 4;
  localparam int DIVIDER_BIT = 5;
  localparam int PREAMP_BIT = 5;
  localparam int REMOTE_LSB = 3;
  // reset value of every configuration byte
  localparam logic [7:0] CFG_RESET = 8'h00;
  // slot limits
  localparam logic [3:0] MAX_SLOTS = 4'hB;
  // slot duration factors
  localparam logic [4:0] BASE_SLOW = 5'h03;
  localparam logic [4:0] BASE_FAST = 5'h01;
  // filter clocks per slow clock
  localparam logic [7:0] FIR_PER_SLOW = 8'h30;
  localparam logic [7:0] FIR_PER_SLOW_FAST = 8'h66;
  // slow clock rate and system clock rate
  localparam int SLOW_CLOCK_HZ = 32768;
  localparam int SYS_CLOCK_HZ = 100000000;
  // chop modes
  localparam logic [1:0] CHOP_AUTO = 2'h0;
  localparam logic [1:0] CHOP_HIGH = 2'h1;
  localparam logic [1:0] CHOP_LOW = 2'h2;
  // frame controller states
  typedef enum logic [1:0] {ST_IDLE, ST_SLOT, ST_TAIL} adcmx_state_type;
endpackage : adcmx_pkg

// [hdl/adcmx_timing_if.sv]
// timing fields and derived durations between sequencer parts
interface adcmx_timing_if;
  logic [1:0] filterLength;
  logic dividerBit;
  logic pllFast;
  logic [3:0] slotCount;
  logic [4:0] slotDuration;
  logic [2:0] tailDuration;
  logic [8:0] frameSlow;
  logic [15:0] frameFir;
  modport calc (
    input filterLength, dividerBit, pllFast, slotCount,
    output slotDuration, tailDuration, frameSlow, frameFir
  );
  modport user (
    output filterLength, dividerBit, pllFast, slotCount,
    input slotDuration, tailDuration, frameSlow, frameFir
  );
endinterface : adcmx_timing_if

// [hdl/adcmx_slow_tick.sv]
// slow clock synchroniser and rising edge enable
module adcmx_slow_tick
  import adcmx_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // slow clock pin and enable
  input wire logic slowClock,
  output logic slowTick
);
  logic sync1_r;
  logic sync2_r;
  logic last_r;

  // two-stage synchroniser, then edge history
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      last_r <= 1'b0;
    end
    else
    begin
      sync1_r <= slowClock;
      sync2_r <= sync1_r;
      last_r <= sync2_r;
    end
  end

  // one enable per slow clock rising edge
  assign slowTick = sync2_r & ~last_r;
endmodule : adcmx_slow_tick

// [hdl/adcmx_timing.sv]
// slot and frame durations from the clock fields
module adcmx_timing
  import adcmx_pkg::*;
(
  // fields in, durations out
  adcmx_timing_if.calc tim
);
  logic [4:0] base;
  logic [4:0] lenFactor;
  logic [4:0] divFactor;
  logic [9:0] slotProduct;
  logic [8:0] slotTotal;
  logic [7:0] firFactor;
  logic [16:0] firProduct;

  // overhead cycles per frame, also the slot base factor
  assign base = tim.pllFast ? BASE_FAST : BASE_SLOW;
  assign lenFactor = 5'({3'h0, tim.filterLength}) + 5'h01;
  assign divFactor = tim.dividerBit ? 5'h02 : 5'h01;
  // slot duration in slow clocks
  assign slotProduct = 10'(base * lenFactor * divFactor);
  assign tim.slotDuration = slotProduct[4:0];
  assign tim.tailDuration = base[2:0];
  // frame duration in slow clocks
  assign slotTotal = {4'h0, tim.slotDuration} * {5'h00, tim.slotCount};
  assign tim.frameSlow = slotTotal + 9'({4'h0, base});
  // frame duration in filter clocks
  assign firFactor = tim.pllFast ? (FIR_PER_SLOW + FIR_PER_SLOW_FAST) : FIR_PER_SLOW;
  assign firProduct = {8'h00, tim.frameSlow} * {9'h000, firFactor};
  assign tim.frameFir = firProduct[15:0];
endmodule : adcmx_timing

// [hdl/adcmx_frame_sequencer.sv]
// converter multiplexer frame sequencer with its configuration bytes
// Overview of operation
// - controller timing counts cycles of the 32768 Hz slow clock
// - controller drives mux advance, filter start, reference chop and engine launch
// - chop enable, slot count, filter length and divider bit govern the controller
// - every multiplexer state begins on a slow clock rising edge
// - slot lasts (3-2*fast)*(length+1)*(divider+1) slow clocks
// - frame lasts (3-2*fast) plus slot duration times slot count
// - frame in filter clocks is slow frame length times (48+102*fast)
// - up to eleven slots per frame, number from the slot count field
// - each slot's 4-bit select picks input handle 0 to 10, bytes 0x2100-0x2105
// - remote current samples bypass the mux, taken in second half of frame
// - filler slots use a valid unused handle; still converted and stored
// - remote samples go straight to their engine RAM location
// - all configuration bytes reset and wake to zero and are read/write
module adcmx_frame_sequencer
  import adcmx_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // wake from battery mode clears the configuration
  input wire logic wakeClear,
  // slow clock from the clock generator
  input wire logic slowClock,
  // register port
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regReadData,
  // converter and filter controls
  output logic [3:0] slotInputSelect,
  output logic muxAdvance,
  output logic filterStart,
  output logic referenceSignalA,
  output logic engineStart,
  // remote sensor sampling
  output logic remoteSampleWindow,
  output logic [2:0] remoteSampleStrobe,
  // analog front end configuration
  output logic [3:0] differentialPairEnable,
  output logic [2:0] remoteSensorEnable,
  output logic preampEnable,
  output logic [1:0] filterLength,
  output logic dividerBit,
  output logic pllFast
);
  // configuration bytes
  logic [7:0] selByte_r [SEL_BYTES];
  logic [7:0] chop_r;
  logic [7:0] filterDiff_r;
  logic [7:0] clockCfg_r;
  logic [7:0] preamp_r;
  logic [7:0] remote_r;
  logic [7:0] readData_r;
  // frame controller state
  adcmx_state_type state_r;
  adcmx_state_type state_nxt;
  logic [3:0] slot_r;
  logic [3:0] slot_nxt;
  logic [4:0] slotCnt_r;
  logic [4:0] slotCnt_nxt;
  logic [8:0] frameCnt_r;
  logic [8:0] frameCnt_nxt;
  logic [3:0] select_r;
  logic chop_r_state;
  logic advance_r;
  logic start_r;
  logic engine_r;
  logic window_r;
  logic [2:0] remoteStrobe_r;
  // decoded and derived signals
  logic slowTick;
  logic [3:0] countRaw;
  logic [3:0] slotCount;
  logic [1:0] chopMode;
  logic frameBegin;
  logic slotEnd;
  logic lastSlot;
  logic tailEnd;
  logic halfPoint;
  logic [7:0] statusByte;
  logic [7:0] readMux;
  logic selHit;
  logic [2:0] selIndex;

  adcmx_timing_if tim ();

  // select field for a slot: slot 0 low nibble of 0x2105, slot 10 of 0x2100
  function automatic logic [3:0] slotSelect(input logic [3:0] slot,
                                            input logic [47:0] bytes);
    logic [2:0] idx;
    logic [7:0] b;
    idx = 3'(SEL_BYTES - 1) - slot[3:1];
    b = bytes[8*idx +: 8];
    return slot[0] ? b[7:4] : b[3:0];
  endfunction : slotSelect

  // byte index of a select address, valid only when hit
  function automatic logic [2:0] selOffset(input logic [15:0] addr);
    return addr[2:0];
  endfunction : selOffset

  // slow clock synchroniser
  adcmx_slow_tick tickGen (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .slowClock(slowClock),
    .slowTick(slowTick)
  );

  // durations derived from the clock fields
  adcmx_timing timing (
    .tim(tim.calc)
  );

  // governing fields
  assign countRaw = selByte_r[0][SLOT_COUNT_LSB +: 4];
  assign slotCount = (countRaw > MAX_SLOTS) ? MAX_SLOTS : countRaw;
  assign chopMode = chop_r[CHOP_LSB +: 2];
  assign tim.filterLength = filterDiff_r[FILTER_LEN_LSB +: 2];
  assign tim.dividerBit = clockCfg_r[DIVIDER_BIT];
  assign tim.pllFast = clockCfg_r[PLL_FAST_BIT];
  assign tim.slotCount = slotCount;

  // register address decode
  assign selHit = (regAddr >= ADDR_SEL10_COUNT) && (regAddr <= ADDR_SEL0_SEL1);
  assign selIndex = selOffset(regAddr);

  // configuration writes, cleared on reset and on wake
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < SEL_BYTES; i++)
        selByte_r[i] <= CFG_RESET;
      chop_r <= CFG_RESET;
      filterDiff_r <= CFG_RESET;
      clockCfg_r <= CFG_RESET;
      preamp_r <= CFG_RESET;
      remote_r <= CFG_RESET;
    end
    else if (wakeClear)
    begin
      for (int i = 0; i < SEL_BYTES; i++)
        selByte_r[i] <= CFG_RESET;
      chop_r <= CFG_RESET;
      filterDiff_r <= CFG_RESET;
      clockCfg_r <= CFG_RESET;
      preamp_r <= CFG_RESET;
      remote_r <= CFG_RESET;
    end
    else if (regWrite)
    begin
      if (selHit)
        selByte_r[selIndex] <= regWriteData;
      if (regAddr == ADDR_CHOP)
        chop_r <= regWriteData;
      if (regAddr == ADDR_FILTER_DIFF)
        filterDiff_r <= regWriteData;
      if (regAddr == ADDR_CLOCK_CFG)
        clockCfg_r <= regWriteData;
      if (regAddr == ADDR_PREAMP)
        preamp_r <= regWriteData;
      if (regAddr == ADDR_REMOTE)
        remote_r <= regWriteData;
    end
  end

  // read selection; status and frame length are read-only
  assign statusByte = {(state_r != ST_IDLE), window_r, referenceSignalA, 1'b0, slot_r};
  assign readMux = selHit ? selByte_r[selIndex] :
                   (regAddr == ADDR_CHOP) ? chop_r :
                   (regAddr == ADDR_FILTER_DIFF) ? filterDiff_r :
                   (regAddr == ADDR_CLOCK_CFG) ? clockCfg_r :
                   (regAddr == ADDR_PREAMP) ? preamp_r :
                   (regAddr == ADDR_REMOTE) ? remote_r :
                   (regAddr == ADDR_STATUS) ? statusByte :
                   (regAddr == ADDR_FRAME_FIR_LO) ? tim.frameFir[7:0] :
                   (regAddr == ADDR_FRAME_FIR_HI) ? tim.frameFir[15:8] :
                   8'h00;

  // read data one cycle after the strobe
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      readData_r <= 8'h00;
    else if (regRead)
      readData_r <= readMux;
  end
  assign regReadData = readData_r;

  // frame controller events, all on slow clock edges
  assign frameBegin = slowTick && (slotCount != 4'h0) &&
                      ((state_r == ST_IDLE) || tailEnd);
  assign slotEnd = (slotCnt_r == tim.slotDuration - 5'h01);
  assign lastSlot = (slot_r >= slotCount - 4'h1);
  assign tailEnd = (state_r == ST_TAIL) &&
                   (slotCnt_r == 5'({2'h0, tim.tailDuration}) - 5'h01);
  assign halfPoint = (frameCnt_r == (tim.frameSlow >> 1));

  // next state of the frame controller
  always_comb
  begin
    state_nxt = state_r;
    slot_nxt = slot_r;
    slotCnt_nxt = slotCnt_r;
    frameCnt_nxt = frameCnt_r;
    if (slowTick)
    begin
      frameCnt_nxt = frameCnt_r + 9'h001;
      slotCnt_nxt = slotCnt_r + 5'h01;
      case (state_r)
        ST_IDLE:
        begin
          slotCnt_nxt = 5'h00;
          frameCnt_nxt = 9'h000;
        end
        ST_SLOT:
        begin
          if (slotCount == 4'h0)
          begin
            state_nxt = ST_IDLE;
            slot_nxt = 4'h0;
          end
          else if (slotEnd)
          begin
            slotCnt_nxt = 5'h00;
            if (lastSlot)
              state_nxt = ST_TAIL;
            else
              slot_nxt = slot_r + 4'h1;
          end
        end
        ST_TAIL:
        begin
          if (tailEnd)
          begin
            state_nxt = ST_IDLE;
            slot_nxt = 4'h0;
          end
        end
        default:
          state_nxt = ST_IDLE;
      endcase
      if (frameBegin)
      begin
        state_nxt = ST_SLOT;
        slot_nxt = 4'h0;
        slotCnt_nxt = 5'h00;
        frameCnt_nxt = 9'h001;
      end
    end
  end

  // frame controller registers
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= ST_IDLE;
      slot_r <= 4'h0;
      slotCnt_r <= 5'h00;
      frameCnt_r <= 9'h000;
    end
    else
    begin
      state_r <= state_nxt;
      slot_r <= slot_nxt;
      slotCnt_r <= slotCnt_nxt;
      frameCnt_r <= frameCnt_nxt;
    end
  end

  // mux advance, filter start and engine launch pulses
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      advance_r <= 1'b0;
      start_r <= 1'b0;
      engine_r <= 1'b0;
      select_r <= 4'h0;
    end
    else
    begin
      advance_r <= frameBegin || (slowTick && state_r == ST_SLOT && slotEnd && !lastSlot
                   && slotCount != 4'h0);
      start_r <= frameBegin || (slowTick && state_r == ST_SLOT && slotEnd && !lastSlot
                 && slotCount != 4'h0);
      engine_r <= frameBegin;
      // filler slots are converted like any other handle
      select_r <= slotSelect(slot_nxt, {selByte_r[5], selByte_r[4], selByte_r[3],
                  selByte_r[2], selByte_r[1], selByte_r[0]});
    end
  end

  // reference chopping, toggled once per frame in auto mode
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      chop_r_state <= 1'b0;
    else if (chopMode == CHOP_HIGH)
      chop_r_state <= 1'b1;
    else if (chopMode == CHOP_LOW)
      chop_r_state <= 1'b0;
    else if (frameBegin)
      chop_r_state <= ~chop_r_state;
  end

  // remote sampling in second half of the frame, outside the mux
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      window_r <= 1'b0;
      remoteStrobe_r <= 3'h0;
    end
    else
    begin
      if (frameBegin || state_nxt == ST_IDLE)
        window_r <= 1'b0;
      else if (slowTick && halfPoint)
        window_r <= 1'b1;
      // one store request per enabled remote sensor
      remoteStrobe_r <= (slowTick && halfPoint && state_r != ST_IDLE) ?
                        remote_r[REMOTE_LSB +: 3] : 3'h0;
    end
  end

  // outputs
  assign slotInputSelect = select_r;
  assign muxAdvance = advance_r;
  assign filterStart = start_r;
  assign engineStart = engine_r;
  assign referenceSignalA = chop_r_state;
  assign remoteSampleWindow = window_r;
  assign remoteSampleStrobe = remoteStrobe_r;
  assign differentialPairEnable = filterDiff_r[DIFF_LSB +: 4];
  assign remoteSensorEnable = remote_r[REMOTE_LSB +: 3];
  assign preampEnable = preamp_r[PREAMP_BIT];
  assign filterLength = tim.filterLength;
  assign dividerBit = tim.dividerBit;
  assign pllFast = tim.pllFast;
endmodule : adcmx_frame_sequencer

// [test/adcmx_frame_sequencer_asserts.sv]
// concurrent checks on the frame sequencer ports
module adcmx_frame_sequencer_asserts
  import adcmx_pkg::*;
(
  // clock, reset and inputs
  input logic clk_sys,
  input logic arst_n,
  input logic wakeClear,
  input logic slowClock,
  input logic [15:0] regAddr,
  input logic [7:0] regWriteData,
  input logic regWrite,
  input logic regRead,
  // outputs
  input logic [7:0] regReadData,
  input logic muxAdvance,
  input logic filterStart,
  input logic engineStart,
  input logic [2:0] remoteSampleStrobe,
  input logic [3:0] differentialPairEnable,
  input logic [2:0] remoteSensorEnable,
  input logic preampEnable,
  input logic [1:0] filterLength,
  input logic dividerBit,
  input logic pllFast
);
  timeunit 1ns;
  timeprecision 1ps;
  logic slowPrev_r;
  logic seenAdv_r;
  logic [7:0] lastWd_r;
  int riseCnt_r;
  int slotDur;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  // slot length in slow ticks from the live fields
  assign slotDur = (pllFast ? 1 : 3) * (int'(filterLength) + 1) * (int'(dividerBit) + 1);
  // slow rises since the last slot start, last write data
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      slowPrev_r <= 1'b0;
      seenAdv_r <= 1'b0;
      lastWd_r <= 8'h00;
      riseCnt_r <= 0;
    end
    else
    begin
      slowPrev_r <= slowClock;
      lastWd_r <= regWriteData;
      seenAdv_r <= seenAdv_r | muxAdvance;
      riseCnt_r <= muxAdvance ? 0 : riseCnt_r + int'(slowClock && !slowPrev_r);
    end
  end
  chk_filter_with_mux:
    assert property (muxAdvance || filterStart |-> muxAdvance && filterStart)
    else $error("filter start and mux advance differ");
  chk_engine_slot_zero:
    assert property (engineStart |-> muxAdvance)
    else $error("engine start without slot start");
  chk_pulse_spacing:
    assert property (muxAdvance |=> !muxAdvance [*8])
    else $error("slot starts too close");
  chk_tick_aligned:
    assert property (muxAdvance |-> slowClock && !$past(slowClock, 8))
    else $error("slot start not after a slow rise");
  chk_slot_length:
    assert property (muxAdvance && !engineStart && seenAdv_r |-> riseCnt_r == slotDur)
    else $error("slot length wrong");
  chk_filter_fields:
    assert property (regWrite && regAddr == ADDR_FILTER_DIFF && !wakeClear |=>
      filterLength == lastWd_r[2:1] && differentialPairEnable == lastWd_r[7:4])
    else $error("filter byte fields not taken");
  chk_clock_fields:
    assert property (regWrite && regAddr == ADDR_CLOCK_CFG && !wakeClear |=>
      dividerBit == lastWd_r[5] && pllFast == lastWd_r[4])
    else $error("clock byte fields not taken");
  chk_wake_clears:
    assert property (wakeClear |=> filterLength == 2'h0 && !dividerBit && !pllFast &&
      !preampEnable && differentialPairEnable == 4'h0 && remoteSensorEnable == 3'h0)
    else $error("wake did not clear fields");
  chk_read_back:
    assert property (regWrite && regAddr == ADDR_CHOP && !wakeClear ##1 !regWrite &&
      !wakeClear ##1 regRead && regAddr == ADDR_CHOP && !wakeClear |=>
      regReadData == $past(regWriteData, 3))
    else $error("chop byte read back wrong");
  chk_strobe_enabled:
    assert property (remoteSampleStrobe != 3'h0 |->
      (remoteSampleStrobe & ~$past(remoteSensorEnable)) == 3'h0)
    else $error("strobe on a disabled remote pair");
endmodule : adcmx_frame_sequencer_asserts

bind adcmx_frame_sequencer adcmx_frame_sequencer_asserts u_asserts (.*);

// [test/adcmx_slow_source.sv]
// slow clock source standing in for the clock generator
module adcmx_slow_source #(
  parameter int HALF_NS = 120
)
(
  // slow clock to the sequencer
  output logic slowClock
);
  timeunit 1ns;
  timeprecision 1ps;
  // free running, scaled down so frames stay short in simulation
  initial
  begin
    slowClock = 1'b0;
    #3;
    forever #(HALF_NS) slowClock = ~slowClock;
  end
endmodule : adcmx_slow_source

// [test/adcmx_frame_sequencer_test.sv]
// self-checking bench for the converter frame sequencer
module adcmx_frame_sequencer_test
  import adcmx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic wakeClear = 1'b0;
  logic slowClock;
  logic [15:0] regAddr = 16'h0000;
  logic [7:0] regWriteData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regReadData;
  logic [3:0] slotInputSelect, differentialPairEnable;
  logic muxAdvance, filterStart, referenceSignalA, engineStart, remoteSampleWindow;
  logic [2:0] remoteSampleStrobe, remoteSensorEnable;
  logic preampEnable, dividerBit, pllFast;
  logic [1:0] filterLength;
  int errTotal = 0;
  int nChecks = 0;
  logic [31:0] lfsr = 32'hFD45A7C0;
  int regModel [int];
  // mapped configuration bytes
  logic [15:0] cfgAddr [11] = '{ADDR_SEL10_COUNT, 16'h2101, 16'h2102, 16'h2103, 16'h2104,
    ADDR_SEL0_SEL1, ADDR_CHOP, ADDR_FILTER_DIFF, ADDR_CLOCK_CFG, ADDR_PREAMP, ADDR_REMOTE};
  // frame set-ups: fast, length, divider, count, chop, sensors (1 shunt+remote, 2 all pairs)
  int cfgRun [5][6] = '{'{0, 0, 0, 1, 0, 0}, '{0, 1, 1, 6, 1, 1}, '{1, 3, 0, 11, 2, 0},
    '{1, 0, 0, 12, 3, 0}, '{0, 3, 1, 11, 0, 2}};
  always #5 clk_sys = ~clk_sys;
  adcmx_slow_source #(.HALF_NS(120)) u_slow (.slowClock(slowClock));
  adcmx_frame_sequencer u_dut (.*);
  // random bytes from the shift register
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04C11DB7 : 32'h00000000);
    return lfsr[7:0];
  endfunction : rnd
  // byte the model expects at an address
  function automatic logic [7:0] mv(input logic [15:0] a);
    return regModel.exists(a) ? 8'(regModel[a]) : 8'h00;
  endfunction : mv
  // compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  // one register write cycle
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    regModel[a] = d;
  endtask : wr
  // one register read cycle, data taken the cycle after
  task automatic rdChk(input logic [15:0] a);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    @(negedge clk_sys);
    check("read data", {8'h00, regReadData}, {8'h00, mv(a)});
  endtask : rdChk
  // configuration pins against the model
  task automatic portChk();
    logic [7:0] f, k, p, r;
    f = mv(ADDR_FILTER_DIFF);
    k = mv(ADDR_CLOCK_CFG);
    p = mv(ADDR_PREAMP);
    r = mv(ADDR_REMOTE);
    check("config pins", {4'h0, differentialPairEnable, filterLength, dividerBit, pllFast,
      preampEnable, remoteSensorEnable}, {4'h0, f[7:4], f[2:1], k[5], k[4], p[5], r[5:3]});
  endtask : portChk
  // bounded wait for a frame start
  task automatic waitStart();
    int t;
    t = 0;
    do
    begin
      @(negedge clk_sys);
      t++;
    end
    while (engineStart !== 1'b1 && t < 20000);
    check("frame start", 16'(engineStart), 16'h0001);
  endtask : waitStart
  // program one set-up and measure a whole frame
  task automatic runFrame(input int fast, input int len, input int dv, input int cnt,
    input int chop, input int setup);
    int sel [11];
    int slots, fr, rises, adv, half;
    logic [2:0] strobes;
    logic c0, prevSlow;
    wr(ADDR_SEL10_COUNT, 8'h00);
    wr(ADDR_FILTER_DIFF, 8'(len * 2) | (setup == 1 ? 8'h10 :
      setup == 2 ? 8'hF0 : rnd() & 8'hF0));
    wr(ADDR_CLOCK_CFG, 8'(fast * 16 + dv * 32));
    wr(ADDR_CHOP, 8'(chop * 4));
    wr(ADDR_REMOTE, setup == 1 ? 8'h38 : setup == 2 ? 8'h00 : rnd() & 8'h38);
    foreach (sel[n])
      sel[n] = int'(rnd()) % 11;
    slots = cnt > 11 ? 11 : cnt;
    // phase voltages in the last three slots when remote currents are in use
    if (setup == 1)
      for (int n = 0; n < 3; n++)
        sel[slots - 3 + n] = 8 + n;
    wr(ADDR_SEL10_COUNT, 8'(cnt * 16 + sel[10]));
    for (int j = 0; j < 5; j++)
      wr(16'h2105 - 16'(j), 8'(sel[2 * j + 1] * 16 + sel[2 * j]));
    portChk();
    fr = (3 - 2 * fast) * (1 + (len + 1) * (dv + 1) * slots);
    waitStart(); // settings stay fixed while frames are measured
    c0 = referenceSignalA;
    half = -1;
    adv = 0;
    rises = 0;
    strobes = 3'h0;
    do
    begin
      if (muxAdvance)
      begin
        check("slot select", 16'(slotInputSelect), 16'(sel[adv % 11]));
        adv++;
      end
      strobes |= remoteSampleStrobe;
      if (remoteSampleWindow && half < 0)
        half = rises;
      prevSlow = slowClock;
      @(negedge clk_sys);
      rises += int'(slowClock && !prevSlow);
    end
    while (engineStart !== 1'b1 && rises < 400);
    check("frame ticks", 16'(rises), 16'(fr));
    check("slots in frame", 16'(adv), 16'(slots));
    check("remote strobes", 16'(strobes), 16'(mv(ADDR_REMOTE) >> 3));
    check("window start", 16'(half), 16'(fr / 2));
    if (chop == 1 || chop == 2)
      check("chop level", {14'h0, c0, referenceSignalA}, chop == 1 ? 16'h3 : 16'h0);
    else
      check("chop toggle", 16'(c0 ^ referenceSignalA), 16'h0001);
    regModel[ADDR_FRAME_FIR_LO] = (fr * (48 + 102 * fast)) % 256;
    regModel[ADDR_FRAME_FIR_HI] = (fr * (48 + 102 * fast)) / 256;
    rdChk(ADDR_FRAME_FIR_LO);
    rdChk(ADDR_FRAME_FIR_HI);
  endtask : runFrame
  // wake clear: bytes to zero, frames stop
  task automatic wakeChk();
    int moves;
    moves = 0;
    @(posedge clk_sys);
    wakeClear <= 1'b1;
    @(posedge clk_sys);
    wakeClear <= 1'b0;
    regModel.delete();
    repeat (2000)
    begin
      @(negedge clk_sys);
      moves += int'(muxAdvance);
    end
    check("slot starts after wake", 16'(moves), 16'h0000);
    foreach (cfgAddr[i])
      rdChk(cfgAddr[i]);
    portChk();
  endtask : wakeChk
  // verdict and end of run
  task automatic endOfTest();
    $display("checks %0d mismatches %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : endOfTest
  // main sequence
  initial
  begin
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    foreach (cfgAddr[i])
      rdChk(cfgAddr[i]);
    foreach (cfgAddr[i])
    begin
      wr(cfgAddr[i], i == 0 ? rnd() & 8'h0F : rnd());
      rdChk(cfgAddr[i]);
    end
    wr(16'h2050, 8'hA5);
    regModel.delete(16'h2050);
    rdChk(16'h2050);
    portChk();
    wakeChk();
    for (int k = 0; k < 5; k++)
      runFrame(cfgRun[k][0], cfgRun[k][1], cfgRun[k][2], cfgRun[k][3], cfgRun[k][4],
        cfgRun[k][5]);
    wakeChk();
    endOfTest();
  end
  // watchdog
  initial
  begin
    #1000000;
    errTotal++;
    endOfTest();
  end
endmodule : adcmx_frame_sequencer_test
